/* rqu_pkg.sv */
// Shared constants and carriers for the reactive-power/undervoltage decoupling element
package rqu_pkg;

  // Clock and trip delay, the cycle count derived from the printed time
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TRIP_DELAY_NS  = 500000000;
  localparam int unsigned TRIP_DELAY_CYC = TRIP_DELAY_NS / CLK_PERIOD_NS;

  // Undervoltage limit as a fraction of nominal: 85 / 100
  localparam int unsigned UV_NUM = 85;
  localparam int unsigned UV_DEN = 100;

  // Field widths of the measurement front end
  localparam int unsigned V_W   = 16;  // Phase-to-phase voltage magnitude
  localparam int unsigned I_W   = 16;  // Positive-sequence current magnitude
  localparam int unsigned P_W   = 24;  // Signed positive-sequence powers
  localparam int unsigned TAN_W = 16;  // Angle limit as tangent, 8.8 fixed point
  localparam int unsigned TAN_FRAC = 8;

  // Register byte offsets
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_STATE  = 6'h04;
  localparam logic [5:0] OFS_EVENT  = 6'h08;
  localparam logic [5:0] OFS_MASK   = 6'h0C;
  localparam logic [5:0] OFS_VNOM   = 6'h10;
  localparam logic [5:0] OFS_QMIN   = 6'h14;
  localparam logic [5:0] OFS_IMIN   = 6'h18;
  localparam logic [5:0] OFS_TAN    = 6'h1C;

  // Control bit positions
  localparam int unsigned CTRL_W      = 5;
  localparam int unsigned CB_ENABLE   = 0;  // Whole element on
  localparam int unsigned CB_METHOD   = 1;  // 0 power angle, 1 pure reactive power
  localparam int unsigned CB_IGATE    = 2;  // Minimum current gate in method 1
  localparam int unsigned CB_DIR_NEG  = 3;  // Reverse reactive power sign
  localparam int unsigned CB_VTS_EN   = 4;  // Honour VT supervision failure

  // Event / status bit positions
  localparam int unsigned EV_W      = 4;
  localparam int unsigned EV_PICKUP = 0;
  localparam int unsigned EV_GEN    = 1;
  localparam int unsigned EV_PCC    = 2;
  localparam int unsigned EV_VTBLK  = 3;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [V_W-1:0]    VNOM_RST = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Measurements from the front end
  typedef struct packed {
    logic signed [P_W-1:0] q1;   // Positive-sequence reactive power
    logic signed [P_W-1:0] p1;   // Positive-sequence active power
    logic [I_W-1:0]        i1;   // Positive-sequence current
    logic [V_W-1:0]        v12;  // Line-to-line voltages
    logic [V_W-1:0]        v23;
    logic [V_W-1:0]        v31;
  } rqu_meas_type;

  // Settings handed to the pickup logic
  typedef struct packed {
    logic              method_q;
    logic              igate_en;
    logic              dir_neg;
    logic [V_W-1:0]    vnom;
    logic [P_W-1:0]    qmin;
    logic [I_W-1:0]    imin;
    logic [TAN_W-1:0]  tan_lim;
  } rqu_cfg_type;

endpackage

/* rqu_delay_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// Delay stage: counts while pickup runs, flags expiry
module rqu_delay_timer
  import rqu_pkg::*;
#(
  parameter logic [31:0] LIMIT = 32'h0000_0001
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  output var  logic [31:0] count,
  output var  logic        expired
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [31:0] count_reg;    // Cycles of continuous pickup
  logic        expired_reg;  // Delay elapsed

  // Count up while running, back to zero the moment pickup drops
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_reg <= 32'h0000_0000;
    end else if (count_reg != LIMIT) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // Expiry is held only while pickup keeps running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= run && (count_reg >= LIMIT - 32'h0000_0001);
    end
  end

  assign count   = count_reg;
  assign expired = expired_reg;

  a_timer_clear: assert property (!run |=> count_reg == 32'h0000_0000)
    else $error("timer not cleared after pickup dropped");
  a_expiry_time: assert property (run && count_reg == LIMIT - 32'h0000_0001 |=> expired_reg)
    else $error("trip missing at end of delay");
  a_early_trip: assert property (expired_reg |-> $past(run) && $past(count_reg) >= LIMIT - 32'h0000_0001)
    else $error("trip before delay elapsed");

endmodule
`default_nettype wire

/* rqu_pickup.sv */
`timescale 1ns/10ps
`default_nettype none
// Pickup decision: three-phase undervoltage AND reactive power drawn from the grid
module rqu_pickup
  import rqu_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire rqu_meas_type meas,
  input  wire rqu_cfg_type  cfg,
  input  wire logic         block,
  output var  logic         pickup
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic              pickup_reg;  // Registered decision
  logic [V_W+7:0]    vlim;        // Nominal scaled by the limit ratio
  logic [2:0]        uv_ph;       // Per-phase undervoltage
  logic              uv_all;
  logic signed [P_W:0] q_int;     // Element-local reactive power
  logic signed [P_W:0] p_ext;
  logic [P_W-1:0]    q_mag;
  logic [P_W-1:0]    p_abs;
  logic              i_ok;
  logic              q_ind;
  logic              ang_hit;
  logic              q_hit;
  logic              react;

  // Line-to-line only, so neutral displacement never enters the decision
  assign vlim = (V_W + 8)'(cfg.vnom * UV_NUM);
  assign uv_ph[0] = (V_W + 8)'(meas.v12 * UV_DEN) < vlim;
  assign uv_ph[1] = (V_W + 8)'(meas.v23 * UV_DEN) < vlim;
  assign uv_ph[2] = (V_W + 8)'(meas.v31 * UV_DEN) < vlim;
  assign uv_all   = &uv_ph;

  // Sign reversal lives only in this local copy; the input is untouched
  assign q_int = cfg.dir_neg ? -$signed({meas.q1[P_W-1], meas.q1})
                             :  $signed({meas.q1[P_W-1], meas.q1});
  assign p_ext = $signed({meas.p1[P_W-1], meas.p1});
  assign q_ind = q_int > 0;
  assign q_mag = q_int[P_W-1:0];
  assign p_abs = p_ext < 0 ? P_W'(-p_ext) : P_W'(p_ext);
  assign i_ok  = meas.i1 >= cfg.imin;

  // Angle beyond limit: Q / |P| above tan(limit), inductive side only
  assign ang_hit = q_ind && ({8'h00, q_mag, 8'h00} >
                   (P_W + TAN_W)'(p_abs * cfg.tan_lim));
  assign q_hit   = q_ind && (q_mag >= cfg.qmin);

  // Method select; the current gate is fixed for the angle method
  always_comb begin
    if (!cfg.method_q) begin
      react = ang_hit && i_ok;
    end else begin
      react = q_hit && (!cfg.igate_en || i_ok);
    end
  end

  // Blocked element never picks up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pickup_reg <= 1'b0;
    end else begin
      pickup_reg <= !block && uv_all && react;
    end
  end

  assign pickup = pickup_reg;

  a_uv_all: assert property (pickup_reg |-> $past(uv_all))
    else $error("pickup without three-phase undervoltage");
  a_angle_gate: assert property (!cfg.method_q && !i_ok && $stable(cfg) |=> !pickup_reg)
    else $error("angle method picked up below minimum current");
  a_block_quiet: assert property (block |=> !pickup_reg)
    else $error("pickup while blocked");
  a_sign_local: assert property (pickup_reg |-> $past(q_int > 0))
    else $error("pickup without inductive reactive power");

endmodule
`default_nettype wire

/* rqu_top.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Trip after pickup held continuously 0.5 s
// - Undervoltage needs all three line voltages low
// - Compare positive-sequence reactive power only
// - Supervise phase-to-phase voltages only
// - Selector between power-angle and pure-reactive methods
// - Minimum positive-sequence current gates reactive criterion
// - Gate always in angle mode, optional otherwise
// - Angle mode uses angle limit and current
// - Reactive mode compares against reactive threshold
// - Generator and coupling-point timers start together
// - Direction setting may invert reactive sign
// - Inversion stays local to this element
// - Disabled element gives no pickup or trip
// - VT failure blocks element when supervised
module rqu_top
  import rqu_pkg::*;
#(
  parameter logic [31:0] GEN_DELAY_CYC = TRIP_DELAY_CYC,  // Generator stage delay
  parameter logic [31:0] PCC_DELAY_CYC = TRIP_DELAY_CYC   // Coupling point stage delay
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite slave
  input  wire logic [5:0]   awaddr,
  input  wire logic         awvalid,
  output var  logic         awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output var  logic         wready,
  output var  logic [1:0]   bresp,
  output var  logic         bvalid,
  input  wire logic         bready,
  input  wire logic [5:0]   araddr,
  input  wire logic         arvalid,
  output var  logic         arready,
  output var  logic [31:0]  rdata,
  output var  logic [1:0]   rresp,
  output var  logic         rvalid,
  input  wire logic         rready,
  // Measurement front end, same clock
  input  wire rqu_meas_type meas,
  // VT supervision failure, asynchronous
  input  wire logic         vt_fail,
  // Results
  output var  logic         pickup,
  output var  logic         trip_gen,
  output var  logic         coupling_point_timer,
  output var  logic         irq
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus handshake state
  logic              awready_reg;  // Low while an address is held
  logic              wready_reg;   // Low while data is held
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [5:0]        waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              do_write;     // Both halves present, response free
  logic [31:0]       wmerge;       // Held data merged over old value
  logic [31:0]       rd_word;
  logic              rd_ok;
  logic              wr_ok;

  // Software registers
  logic [CTRL_W-1:0] ctrl_reg;
  logic [EV_W-1:0]   event_reg;
  logic [EV_W-1:0]   event_next;
  logic [EV_W-1:0]   mask_reg;
  logic [V_W-1:0]    vnom_reg;
  logic [P_W-1:0]    qmin_reg;
  logic [I_W-1:0]    imin_reg;
  logic [TAN_W-1:0]  tan_reg;
  logic              irq_reg;

  // Element state
  logic              vt_s1_reg;    // First synchroniser stage
  logic              vt_s2_reg;    // Safe to use
  logic              vt_blk;
  logic              blk;
  logic [EV_W-1:0]   live;         // Live status word
  logic [EV_W-1:0]   live_prev_reg;
  logic              pickup_w;
  logic              gen_w;
  logic              pcc_w;
  logic [31:0]       gen_count;
  logic [31:0]       pcc_count;
  rqu_cfg_type       cfg;

  // Merge byte lanes of the held write data over a register's old value
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Write address channel: take one, hold until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      waddr_reg   <= 6'h00;
    end else if (awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      waddr_reg   <= awaddr;
    end else if (bvalid_reg && bready) begin
      awready_reg <= 1'b1;
    end
  end

  // Write data channel, independent of the address so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b1;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      wdata_reg  <= wdata;
      wstrb_reg  <= wstrb;
    end else if (bvalid_reg && bready) begin
      wready_reg <= 1'b1;
    end
  end

  assign do_write = !awready_reg && !wready_reg && !bvalid_reg;

  // Old value of the addressed register, for strobe merging
  always_comb begin
    wr_ok  = 1'b1;
    wmerge = 32'h0000_0000;
    case (waddr_reg)
      OFS_CTRL:  wmerge = strb_merge(32'(ctrl_reg), wdata_reg, wstrb_reg);
      OFS_EVENT: wmerge = strb_merge(32'h0000_0000, wdata_reg, wstrb_reg);
      OFS_MASK:  wmerge = strb_merge(32'(mask_reg), wdata_reg, wstrb_reg);
      OFS_VNOM:  wmerge = strb_merge(32'(vnom_reg), wdata_reg, wstrb_reg);
      OFS_QMIN:  wmerge = strb_merge(32'(qmin_reg), wdata_reg, wstrb_reg);
      OFS_IMIN:  wmerge = strb_merge(32'(imin_reg), wdata_reg, wstrb_reg);
      OFS_TAN:   wmerge = strb_merge(32'(tan_reg), wdata_reg, wstrb_reg);
      default:   wr_ok  = 1'b0;  // Status is read only, rest unmapped
    endcase
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Configuration registers; settings change only on a completed bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= '0;
      vnom_reg <= VNOM_RST;
      qmin_reg <= '0;
      imin_reg <= '0;
      tan_reg  <= '0;
    end else if (do_write) begin
      case (waddr_reg)
        OFS_CTRL: ctrl_reg <= wmerge[CTRL_W-1:0];
        OFS_MASK: mask_reg <= wmerge[EV_W-1:0];
        OFS_VNOM: vnom_reg <= wmerge[V_W-1:0];
        OFS_QMIN: qmin_reg <= wmerge[P_W-1:0];
        OFS_IMIN: imin_reg <= wmerge[I_W-1:0];
        OFS_TAN:  tan_reg  <= wmerge[TAN_W-1:0];
        default:  ;
      endcase
    end
  end

  // Read mux; reserved bits read as zero
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (araddr)
      OFS_CTRL:  rd_word = 32'(ctrl_reg);
      OFS_STATE: rd_word = 32'(live);
      OFS_EVENT: rd_word = 32'(event_reg);
      OFS_MASK:  rd_word = 32'(mask_reg);
      OFS_VNOM:  rd_word = 32'(vnom_reg);
      OFS_QMIN:  rd_word = 32'(qmin_reg);
      OFS_IMIN:  rd_word = 32'(imin_reg);
      OFS_TAN:   rd_word = 32'(tan_reg);
      default:   rd_ok   = 1'b0;
    endcase
  end

  // Read channel: capture word with the address, hold until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // VT failure comes from another domain; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vt_s1_reg <= 1'b0;
      vt_s2_reg <= 1'b0;
    end else begin
      vt_s1_reg <= vt_fail;
      vt_s2_reg <= vt_s1_reg;
    end
  end

  assign vt_blk = ctrl_reg[CB_VTS_EN] && vt_s2_reg;
  assign blk    = !ctrl_reg[CB_ENABLE] || vt_blk;

  assign cfg.method_q = ctrl_reg[CB_METHOD];
  assign cfg.igate_en = ctrl_reg[CB_IGATE];
  assign cfg.dir_neg  = ctrl_reg[CB_DIR_NEG];
  assign cfg.vnom     = vnom_reg;
  assign cfg.qmin     = qmin_reg;
  assign cfg.imin     = imin_reg;
  assign cfg.tan_lim  = tan_reg;

  rqu_pickup u_pickup (
    .aclk    (aclk),
    .aresetn (aresetn),
    .meas    (meas),
    .cfg     (cfg),
    .block   (blk),
    .pickup  (pickup_w)
  );

  // Both stages start from the same pickup
  rqu_delay_timer #(.LIMIT(GEN_DELAY_CYC)) u_gen_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (pickup_w),
    .count   (gen_count),
    .expired (gen_w)
  );

  rqu_delay_timer #(.LIMIT(PCC_DELAY_CYC)) u_pcc_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (pickup_w),
    .count   (pcc_count),
    .expired (pcc_w)
  );

  assign live = {vt_blk, pcc_w, gen_w, pickup_w};

  // Rising edges of live state become sticky events; set beats clear
  always_comb begin
    event_next = event_reg;
    if (do_write && waddr_reg == OFS_EVENT) begin
      event_next = event_next & ~wmerge[EV_W-1:0];
    end
    event_next = event_next | (live & ~live_prev_reg);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_reg     <= '0;
      live_prev_reg <= '0;
      irq_reg       <= 1'b0;
    end else begin
      event_reg     <= event_next;
      live_prev_reg <= live;
      irq_reg       <= |(event_next & mask_reg);
    end
  end

  assign awready              = awready_reg;
  assign wready               = wready_reg;
  assign bvalid               = bvalid_reg;
  assign bresp                = bresp_reg;
  assign arready              = arready_reg;
  assign rvalid               = rvalid_reg;
  assign rdata                = rdata_reg;
  assign rresp                = rresp_reg;
  assign pickup               = pickup_w;
  assign trip_gen             = gen_w;
  assign coupling_point_timer = pcc_w;
  assign irq                  = irq_reg;

  a_timers_start: assert property ($rose(pickup_w) |=> gen_count == 32'h0000_0001 && pcc_count == 32'h0000_0001)
    else $error("timers did not start together on pickup");
  // Pickup answers the enable one cycle later, the stage outputs one cycle after that;
  // looking further ahead would trip on a legal re-enable
  a_disabled_quiet: assert property (!ctrl_reg[CB_ENABLE] |=> !pickup_w ##1 (!gen_w && !pcc_w))
    else $error("activity while element disabled");
  a_vt_blocks: assert property (ctrl_reg[CB_VTS_EN] && vt_s2_reg |=> !pickup_w)
    else $error("pickup during VT failure");
  a_trip_cause: assert property ($rose(gen_w) |-> $past(pickup_w, 1))
    else $error("trip without pickup");
  a_event_set: assert property ($rose(gen_w) |=> event_reg[EV_GEN])
    else $error("trip event not captured");

endmodule
`default_nettype wire

/* rqu_front_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Measurement front end: publishes one reading set per clock, like a sampling ADC chain
module rqu_front_model
  import rqu_pkg::*;
(
  input  wire logic [47:0]  v_set,  // {v12, v23, v31}
  input  wire logic         aclk,
  input  wire logic [23:0]  q_set,  // Signed positive-sequence reactive power
  input  wire logic [23:0]  p_set,  // Signed positive-sequence active power
  input  wire logic [15:0]  i_set,  // Positive-sequence current
  output var  rqu_meas_type meas
);
  // Readings change only after an edge, so the element never sees a half-updated set
  always_ff @(posedge aclk) begin
    meas.q1  <= q_set;
    meas.p1  <= p_set;
    meas.i1  <= i_set;
    meas.v12 <= v_set[47:32];
    meas.v23 <= v_set[31:16];
    meas.v31 <= v_set[15:0];
  end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the decoupling element
module tb
  import rqu_pkg::*;
;
  logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, vt_fail;
  logic         pickup, trip_gen, coupling_point_timer, irq;
  logic [5:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic [47:0]  v_set;     // Three line voltages
  logic [23:0]  q_set, p_set;
  logic [15:0]  i_set;
  rqu_meas_type meas;
  int           fails, n_compared;

  // Short stage delays keep the run brief
  rqu_top #(.GEN_DELAY_CYC(32'h0000_0008), .PCC_DELAY_CYC(32'h0000_0008)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .meas, .vt_fail, .pickup, .trip_gen, .coupling_point_timer, .irq);
  rqu_front_model fm_u (.aclk, .v_set, .q_set, .p_set, .i_set, .meas);

  // 100 ns period
  always #50 aclk = ~aclk;

  task results;
    $display("fails %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  // A wait that ran out ends the run
  task tmo;
    fails++;
    results();
  endtask

  // AXI write: address and data offered together, released as each is taken
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
    end
    bready <= 1'h0;
    if (k == 40) tmo();
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // AXI read; data taken at the edge where rvalid is seen
  task rd(input logic [5:0] a, input logic [1:0] er, output logic [31:0] d);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
    end
    d = rdata;
    rready <= 1'h0;
    if (k == 40) tmo();
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task setm(input logic [15:0] v, input logic [23:0] q, p, input logic [15:0] i);
    @(posedge aclk);
    v_set <= {3{v}};
    q_set <= q;
    p_set <= p;
    i_set <= i;
  endtask

  // Covers front-end register, pickup register and the VT synchroniser
  task pk(input logic e);
    repeat (6) @(posedge aclk);
    #1 chk("pickup", {31'h0, e}, {31'h0, pickup});
  endtask

  // Cycles from pickup rising to the generator stage trip
  task trip_wait(output int k);
    int n;
    for (n = 0; n < 30; n++) begin
      @(posedge aclk);
      #1;
      if (pickup === 1'h1) break;
    end
    if (n == 30) tmo();
    for (k = 0; k < 30 && trip_gen !== 1'h1; k++) begin
      @(posedge aclk);
      #1;
    end
    if (k == 30) tmo();
  endtask

  task s_regs;
    logic [31:0] d;
    rd(OFS_CTRL, RESP_OKAY, d);
    chk("ctrl", 32'h0000_0000, d);
    rd(6'h20, RESP_SLVERR, d);
    wr(OFS_STATE, 32'h0000_000F, RESP_SLVERR);
    wr(OFS_VNOM, 32'h0000_03E8, RESP_OKAY);
    wr(OFS_QMIN, 32'h0000_0064, RESP_OKAY);
    wr(OFS_IMIN, 32'h0000_0032, RESP_OKAY);
    wr(OFS_TAN, 32'h0000_0100, RESP_OKAY);
  endtask

  // Nominal 1000: 850 is not below the limit, 849 is
  task s_uv;
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    setm(16'h0351, 24'h00_00C8, 24'h00_0000, 16'h003C);
    for (int n = 0; n < 3; n++) begin
      @(posedge aclk);
      v_set <= {3{16'h0351}} ^ (48'h0000_0000_0003 << (n * 16));
      pk(1'h0);
    end
    setm(16'h0351, 24'h00_00C8, 24'h00_0000, 16'h003C);
    pk(1'h1);
    setm(16'h0351, 24'h00_0063, 24'h00_0000, 16'h003C);
    pk(1'h0);
    setm(16'h0351, 24'h00_0064, 24'h00_0000, 16'h003C);
    pk(1'h1);
  endtask

  task s_gate;
    wr(OFS_CTRL, 32'h0000_0007, RESP_OKAY);
    setm(16'h0351, 24'h00_00C8, 24'h00_0000, 16'h0031);
    pk(1'h0);
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    pk(1'h1);
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    pk(1'h0);
    setm(16'h0351, 24'h00_0065, 24'h00_0064, 16'h0032);
    pk(1'h1);
    setm(16'h0351, 24'h00_0064, 24'h00_0064, 16'h0032);
    pk(1'h0);
    setm(16'h0351, 24'hFF_FF9B, 24'h00_0064, 16'h0032);
    pk(1'h0);
  endtask

  task s_dir;
    wr(OFS_CTRL, 32'h0000_000B, RESP_OKAY);
    setm(16'h0351, 24'hFF_FF38, 24'h00_0000, 16'h003C);
    pk(1'h1);
    setm(16'h0351, 24'h00_00C8, 24'h00_0000, 16'h003C);
    pk(1'h0);
  endtask

  task s_block;
    wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
    pk(1'h0);
    @(posedge aclk);
    vt_fail <= 1'h1;
    wr(OFS_CTRL, 32'h0000_0013, RESP_OKAY);
    pk(1'h0);
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    pk(1'h1);
    vt_fail <= 1'h0;
  endtask

  // Full delay, interrupted run, events and interrupt
  task s_timer;
    int k;
    logic [31:0] d;
    setm(16'h03E8, 24'h00_00C8, 24'h00_0000, 16'h003C);
    pk(1'h0);
    wr(OFS_MASK, 32'h0000_0001, RESP_OKAY);
    wr(OFS_EVENT, 32'h0000_000F, RESP_OKAY);
    #1 chk("irq", 32'h0, {31'h0, irq});
    setm(16'h0351, 24'h00_00C8, 24'h00_0000, 16'h003C);
    trip_wait(k);
    chk("delay", 32'h0000_0008, k);
    chk("pcc", 32'h1, {31'h0, coupling_point_timer});
    chk("irq", 32'h1, {31'h0, irq});
    setm(16'h03E8, 24'h00_00C8, 24'h00_0000, 16'h003C);
    pk(1'h0);
    chk("trip", 32'h0, {31'h0, trip_gen});
    setm(16'h0351, 24'h00_00C8, 24'h00_0000, 16'h003C);
    repeat (6) @(posedge aclk);
    setm(16'h03E8, 24'h00_00C8, 24'h00_0000, 16'h003C);
    pk(1'h0);
    setm(16'h0351, 24'h00_00C8, 24'h00_0000, 16'h003C);
    trip_wait(k);
    chk("delay", 32'h0000_0008, k);
    setm(16'h03E8, 24'h00_00C8, 24'h00_0000, 16'h003C);
    pk(1'h0);
    rd(OFS_EVENT, RESP_OKAY, d);
    chk("event", 32'h0000_0007, d & 32'h0000_0007);
    wr(OFS_EVENT, 32'h0000_0001, RESP_OKAY);
    @(posedge aclk);
    #1 chk("irq", 32'h0, {31'h0, irq});
  endtask

  initial begin
    fails = 0;
    n_compared = 0;
    aclk = 1'h0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, vt_fail} = 6'h00;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    v_set = {3{16'h03E8}};
    q_set = 24'h00_0000;
    p_set = 24'h00_0000;
    i_set = 16'h0000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    s_regs();
    s_uv();
    s_gate();
    s_dir();
    s_block();
    s_timer();
    results();
  end
endmodule
`default_nettype wire
